//--- hw/eau_core.sv
// Purpose: Arithmetic and logic execution unit of an 8-bit core.
// Assumes: The decoder reads operands from the register file and holds off while busy.
// Notes: Results and flags appear one or two cycles after a taken request.
`timescale 1ns/1ps
`include "eau_params.svh"

module eau_core (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Request from the decoder
	input wire logic req_in,
	input eau_pkg::eau_req_t req_data_in,
	// Answer to the register file
	output logic done_out,
	output eau_pkg::eau_ans_t ans_out,
	output eau_pkg::eau_flags_t flags_out,
	output logic busy_out
);

	function automatic logic is_imm(input eau_pkg::eau_op_t op);
		is_imm = (op == eau_pkg::EAU_MINUS_IMMEDIATE) ||
			(op == eau_pkg::EAU_MINUS_IMMEDIATE_WITH_BORROW) ||
			(op == eau_pkg::EAU_CONJUNCTION_IMMEDIATE) ||
			(op == eau_pkg::EAU_DISJUNCTION_IMMEDIATE) ||
			(op == eau_pkg::EAU_MASK_SET_BITS) ||
			(op == eau_pkg::EAU_MASK_CLEAR_BITS);
	endfunction

	function automatic logic is_two(input eau_pkg::eau_op_t op);
		is_two = (op == eau_pkg::EAU_WORD_IMMEDIATE_SUM) ||
			(op == eau_pkg::EAU_WORD_IMMEDIATE_MINUS) ||
			(op >= eau_pkg::EAU_PRODUCT_UNSIGNED);
	endfunction

	eau_pkg::eau_state_t state_ff;
	eau_pkg::eau_state_t nxt_state;
	eau_pkg::eau_ans_t ans_ff;
	eau_pkg::eau_ans_t nxt_ans;
	eau_pkg::eau_ans_t pend_ans_ff;
	eau_pkg::eau_ans_t nxt_pend_ans;
	eau_pkg::eau_flags_t flags_ff;
	eau_pkg::eau_flags_t nxt_flags;
	eau_pkg::eau_flags_t pend_flags_ff;
	eau_pkg::eau_flags_t nxt_pend_flags;
	logic done_ff;
	logic nxt_done;
	logic busy_ff;
	logic nxt_busy;

	// Datapath results for the request on the input.
	eau_pkg::eau_req_t rq;
	logic [7:0] opb;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [16:0] word17;
	logic [15:0] pair;
	logic [15:0] prod;
	logic [15:0] wide;
	logic signed [8:0] mul_a;
	logic signed [8:0] mul_b;
	logic signed [17:0] mul_full;
	eau_pkg::eau_flags_t cand;
	eau_pkg::eau_flags_t upd;
	eau_pkg::eau_ans_t res;
	logic accept;

	assign rq = req_data_in;
	assign accept = req_in && (state_ff == eau_pkg::EAU_ST_IDLE);
	assign opb = is_imm(rq.op) ? rq.imm : rq.src;
	assign pair = {rq.dst_hi, rq.dst};

	always_comb begin
		cin = 1'b0;
		sum9 = 9'h000;
		nib5 = 5'h00;
		word17 = 17'h00000;
		mul_a = 9'sh000;
		mul_b = 9'sh000;
		mul_full = 18'sh00000;
		prod = 16'h0000;
		wide = 16'h0000;
		cand = `EAU_FLAGS_RST;
		upd = `EAU_FLAGS_RST;
		res = '0;
		res.wr_en = 1'b1;
		res.idx = rq.dst_idx;
		unique case (rq.op)
			eau_pkg::EAU_ADD,
			eau_pkg::EAU_ADD_CARRY: begin
				cin = (rq.op == eau_pkg::EAU_ADD_CARRY) ? flags_ff.c : 1'b0;
				sum9 = {1'b0, rq.dst} + {1'b0, opb} + {8'h00, cin};
				nib5 = {1'b0, rq.dst[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
				res.data = {8'h00, sum9[7:0]};
				cand.c = sum9[`EAU_BYTE_TOP];
				cand.h = nib5[`EAU_NIB_TOP];
				cand.v = (rq.dst[7] == opb[7]) && (sum9[7] != rq.dst[7]);
				upd = '{h: 1'b1, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};
			end
			eau_pkg::EAU_SUB,
			eau_pkg::EAU_MINUS_IMMEDIATE,
			eau_pkg::EAU_MINUS_WITH_BORROW,
			eau_pkg::EAU_MINUS_IMMEDIATE_WITH_BORROW: begin
				cin = ((rq.op == eau_pkg::EAU_MINUS_WITH_BORROW) ||
					(rq.op == eau_pkg::EAU_MINUS_IMMEDIATE_WITH_BORROW)) ? flags_ff.c : 1'b0;
				sum9 = {1'b0, rq.dst} - {1'b0, opb} - {8'h00, cin};
				nib5 = {1'b0, rq.dst[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
				res.data = {8'h00, sum9[7:0]};
				cand.c = sum9[`EAU_BYTE_TOP];
				cand.h = nib5[`EAU_NIB_TOP];
				cand.v = (rq.dst[7] != opb[7]) && (sum9[7] != rq.dst[7]);
				upd = '{h: 1'b1, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};
			end
			eau_pkg::EAU_WORD_IMMEDIATE_SUM,
			eau_pkg::EAU_WORD_IMMEDIATE_MINUS: begin
				if (rq.op == eau_pkg::EAU_WORD_IMMEDIATE_SUM) begin
					word17 = {1'b0, pair} + {9'h000, rq.imm};
					cand.v = !rq.dst_hi[7] && word17[15];
				end else begin
					word17 = {1'b0, pair} - {9'h000, rq.imm};
					cand.v = rq.dst_hi[7] && !word17[15];
				end
				res.data = word17[15:0];
				res.wr_pair = 1'b1;
				cand.c = word17[`EAU_WORD_TOP];
				upd = '{h: 1'b0, s: 1'b1, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b1};
			end
			eau_pkg::EAU_AND,
			eau_pkg::EAU_CONJUNCTION_IMMEDIATE,
			eau_pkg::EAU_OR,
			eau_pkg::EAU_DISJUNCTION_IMMEDIATE,
			eau_pkg::EAU_EXCLUSIVE_DISJUNCTION,
			eau_pkg::EAU_MASK_SET_BITS,
			eau_pkg::EAU_MASK_CLEAR_BITS,
			eau_pkg::EAU_ZERO_SIGN_CHECK: begin
				unique case (rq.op)
					eau_pkg::EAU_AND,
					eau_pkg::EAU_CONJUNCTION_IMMEDIATE: res.data = {8'h00, rq.dst & opb};
					eau_pkg::EAU_EXCLUSIVE_DISJUNCTION: res.data = {8'h00, rq.dst ^ opb};
					eau_pkg::EAU_MASK_SET_BITS: res.data = {8'h00, rq.dst | opb};
					eau_pkg::EAU_MASK_CLEAR_BITS: res.data = {8'h00, rq.dst & (`EAU_FULL_MASK - opb)};
					eau_pkg::EAU_ZERO_SIGN_CHECK: res.data = {8'h00, rq.dst & rq.dst};
					default: res.data = {8'h00, rq.dst | opb};
				endcase
				// Logic results never overflow, so V is forced low here.
				cand.v = 1'b0;
				upd = '{h: 1'b0, s: 1'b0, v: 1'b1, n: 1'b1, z: 1'b1, c: 1'b0};
			end
			default: begin
				// Nine-bit operands cover signed, unsigned and mixed in one multiplier.
				mul_a = (rq.op == eau_pkg::EAU_PRODUCT_UNSIGNED ||
					rq.op == eau_pkg::EAU_FRACTIONAL_PRODUCT_UNSIGNED) ?
					$signed({1'b0, rq.dst}) : $signed({rq.dst[7], rq.dst});
				mul_b = (rq.op == eau_pkg::EAU_PRODUCT_SIGNED ||
					rq.op == eau_pkg::EAU_FRACTIONAL_PRODUCT_SIGNED) ?
					$signed({rq.src[7], rq.src}) : $signed({1'b0, rq.src});
				mul_full = mul_a * mul_b;
				prod = mul_full[15:0];
				cand.c = prod[15];
				wide = (rq.op >= eau_pkg::EAU_FRACTIONAL_PRODUCT_UNSIGNED) ? {prod[14:0], 1'b0} : prod;
				res.data = wide;
				res.wr_pair = 1'b1;
				res.idx = `EAU_PROD_IDX;
				upd = '{h: 1'b0, s: 1'b0, v: 1'b0, n: 1'b0, z: 1'b1, c: 1'b1};
			end
		endcase
		cand.z = res.wr_pair ? (res.data == 16'h0000) : (res.data[7:0] == 8'h00);
		cand.n = res.wr_pair ? res.data[15] : res.data[7];
		cand.s = cand.n ^ cand.v;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_ans = ans_ff;
		nxt_pend_ans = pend_ans_ff;
		nxt_flags = flags_ff;
		nxt_pend_flags = pend_flags_ff;
		nxt_done = 1'b0;
		nxt_busy = busy_ff;
		unique case (state_ff)
			eau_pkg::EAU_ST_IDLE: begin
				if (accept) begin
					if (is_two(rq.op) == `EAU_LAT_TWO) begin
						// Hold the result so the write lands on the second cycle.
						nxt_pend_ans = res;
						nxt_pend_flags = (cand & upd) | (flags_ff & ~upd);
						nxt_state = eau_pkg::EAU_ST_SECOND;
						nxt_busy = 1'b1;
					end else begin
						nxt_ans = res;
						nxt_flags = (cand & upd) | (flags_ff & ~upd);
						nxt_done = 1'b1;
					end
				end
			end
			eau_pkg::EAU_ST_SECOND: begin
				nxt_ans = pend_ans_ff;
				nxt_flags = pend_flags_ff;
				nxt_done = 1'b1;
				nxt_busy = 1'b0;
				nxt_state = eau_pkg::EAU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= eau_pkg::EAU_ST_IDLE;
			ans_ff <= '0;
			pend_ans_ff <= '0;
			flags_ff <= `EAU_FLAGS_RST;
			pend_flags_ff <= `EAU_FLAGS_RST;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ans_ff <= nxt_ans;
			pend_ans_ff <= nxt_pend_ans;
			flags_ff <= nxt_flags;
			pend_flags_ff <= nxt_pend_flags;
			done_ff <= nxt_done;
			busy_ff <= nxt_busy;
		end
	end

	assign done_out = done_ff;
	assign ans_out = ans_ff;
	assign flags_out = flags_ff;
	assign busy_out = busy_ff;

endmodule

//--- pkg/eau_params.svh
// Purpose: Named constants for the 8-bit arithmetic and logic unit.
// Assumes: Included by the design file only.
// Notes: Widths are fixed by the core's 8-bit datapath.
`ifndef EAU_PARAMS_SVH
`define EAU_PARAMS_SVH
`define EAU_FLAGS_RST 6'h00
`define EAU_FULL_MASK 8'hFF
`define EAU_PROD_IDX 5'h00
`define EAU_LAT_ONE 1'h0
`define EAU_LAT_TWO 1'h1
`define EAU_NIB_TOP 4
`define EAU_BYTE_TOP 8
`define EAU_WORD_TOP 16
`endif

//--- pkg/eau_pkg.sv
// Purpose: Types shared by the arithmetic and logic unit and its users.
// Assumes: Nothing is imported; users write eau_pkg::name.
// Notes: Operation codes are stable and ordered: the six products come last, fractional after plain.
package eau_pkg;
	typedef enum logic [4:0] {
		EAU_ADD = 5'h00,
		EAU_ADD_CARRY = 5'h01,
		EAU_WORD_IMMEDIATE_SUM = 5'h02,
		EAU_SUB = 5'h03,
		EAU_MINUS_IMMEDIATE = 5'h04,
		EAU_MINUS_WITH_BORROW = 5'h05,
		EAU_MINUS_IMMEDIATE_WITH_BORROW = 5'h06,
		EAU_WORD_IMMEDIATE_MINUS = 5'h07,
		EAU_AND = 5'h08,
		EAU_CONJUNCTION_IMMEDIATE = 5'h09,
		EAU_OR = 5'h0A,
		EAU_DISJUNCTION_IMMEDIATE = 5'h0B,
		EAU_EXCLUSIVE_DISJUNCTION = 5'h0C,
		EAU_MASK_SET_BITS = 5'h0D,
		EAU_MASK_CLEAR_BITS = 5'h0E,
		EAU_ZERO_SIGN_CHECK = 5'h0F,
		EAU_PRODUCT_UNSIGNED = 5'h10,
		EAU_PRODUCT_SIGNED = 5'h11,
		EAU_PRODUCT_SIGNED_BY_UNSIGNED = 5'h12,
		EAU_FRACTIONAL_PRODUCT_UNSIGNED = 5'h13,
		EAU_FRACTIONAL_PRODUCT_SIGNED = 5'h14,
		EAU_FRACTIONAL_PRODUCT_MIXED = 5'h15
	} eau_op_t;

	typedef enum logic [0:0] {
		EAU_ST_IDLE = 1'b0,
		EAU_ST_SECOND = 1'b1
	} eau_state_t;

	typedef struct packed {
		eau_op_t op;
		logic [4:0] dst_idx;
		logic [7:0] dst_hi;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] imm;
	} eau_req_t;

	typedef struct packed {
		logic wr_en;
		logic wr_pair;
		logic [4:0] idx;
		logic [15:0] data;
	} eau_ans_t;

	typedef struct packed {
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} eau_flags_t;
endpackage

//--- verif/eau_core_props.sv
// Purpose: Timing and flag checks on the arithmetic unit's ports.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: An op is taken whenever busy_out is low at the edge.
`timescale 1ns/1ps
module eau_core_props (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Request and answer
	input wire logic req_in,
	input eau_pkg::eau_req_t req_data_in,
	input wire logic done_out,
	input eau_pkg::eau_ans_t ans_out,
	input eau_pkg::eau_flags_t flags_out,
	input wire logic busy_out
);
	logic wrd, mul, lg, t1, t2;
	assign wrd = req_data_in.op inside {eau_pkg::EAU_WORD_IMMEDIATE_SUM, eau_pkg::EAU_WORD_IMMEDIATE_MINUS};
	assign mul = req_data_in.op >= eau_pkg::EAU_PRODUCT_UNSIGNED;
	assign lg = req_data_in.op >= eau_pkg::EAU_AND && req_data_in.op <= eau_pkg::EAU_MASK_CLEAR_BITS;
	assign t1 = req_in && !busy_out && !wrd && !mul;
	assign t2 = req_in && !busy_out && (wrd || mul);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	one_cycle_done_a: assert property (t1 |=> done_out && !busy_out)
		else $error("single-cycle op answered late");
	two_cycle_done_a: assert property (t2 |=> busy_out && !done_out ##1 done_out && !busy_out)
		else $error("two-cycle op timing wrong");
	done_cause_a: assert property (done_out |-> $past(t1) || $past(t2, 2))
		else $error("done without a taken op");
	busy_once_a: assert property ($rose(busy_out) |=> !busy_out)
		else $error("busy longer than one cycle");
	word_pair_a: assert property (t2 && wrd |-> ##2 ans_out.wr_pair && ans_out.idx == $past(req_data_in.dst_idx, 2))
		else $error("word result not to its pair");
	prod_pair_a: assert property (t2 && mul |-> ##2 ans_out.wr_pair && ans_out.idx == 5'h00)
		else $error("product not to pair one zero");
	flags_hold_a: assert property (!done_out |-> $stable(flags_out))
		else $error("flags moved without a result");
	logic_keep_a: assert property (t1 && lg |=> !flags_out.v && flags_out.c == $past(flags_out.c)
		&& flags_out.h == $past(flags_out.h) && flags_out.s == $past(flags_out.s))
		else $error("logic op disturbed held flags");
	check_keep_a: assert property (t1 && req_data_in.op == eau_pkg::EAU_ZERO_SIGN_CHECK |=>
		ans_out.data[7:0] == $past(req_data_in.dst) && flags_out.z == ($past(req_data_in.dst) == 8'h00))
		else $error("check op changed value or zero flag");
endmodule

bind eau_core eau_core_props u_props (.mclk_in, .rst_n_in, .req_in, .req_data_in, .done_out, .ans_out, .flags_out,
	.busy_out);

//--- verif/eau_rf_model.sv
// Purpose: Register file that takes the unit's write-backs.
// Assumes: Writes land at the edge that ends the done cycle.
// Notes: Not reset, like a real register file.
`timescale 1ns/1ps
module eau_rf_model (
	// Clock
	input wire logic mclk_in,
	// Write-back from the unit
	input wire logic done_in,
	input eau_pkg::eau_ans_t ans_in
);
	logic [7:0] regs [32];
	initial for (int i = 0; i < 32; i++) regs[i] = 8'(i * 29);
	always @(posedge mclk_in) if (done_in && ans_in.wr_en) begin
		regs[ans_in.idx] <= ans_in.data[7:0];
		if (ans_in.wr_pair) regs[ans_in.idx + 5'h01] <= ans_in.data[15:8];
	end
endmodule

//--- verif/eight_bit_arith_logic_unit_bench.sv
// Purpose: Op stream cycling through all 22 codes, with random operands, against an integer model of the unit.
// Assumes: Operands come from a mirror of the register file.
// Notes: Each op waits for the last result, so carry-in is never stale.
`timescale 1ns/1ps
module eight_bit_arith_logic_unit_bench;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic req_in = 1'b0;
	eau_pkg::eau_req_t req_data_in = '0;
	logic done_out, busy_out;
	eau_pkg::eau_ans_t ans_out;
	eau_pkg::eau_flags_t flags_out, mf;
	logic [7:0] mr [32];
	logic [27:0] eq [$];
	logic [27:0] e;
	int n_fail = 0;
	int n_tests = 0;
	always #25 mclk_in = ~mclk_in;
	eau_core u_dut (.mclk_in, .rst_n_in, .req_in, .req_data_in, .done_out, .ans_out, .flags_out, .busy_out);
	eau_rf_model u_rf (.mclk_in, .done_in(done_out), .ans_in(ans_out));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic push(input eau_pkg::eau_req_t q);
		int o, a, b, ci, s, hs;
		logic [15:0] r;
		logic pr;
		logic [4:0] ix;
		o = q.op;
		a = q.dst;
		b = q.src;
		pr = o == 2 || o == 7 || o >= 16;
		ix = (o >= 16) ? 5'h00 : q.dst_idx;
		if (o <= 1 || (o >= 3 && o <= 6)) begin
			if (o == 4 || o == 6) b = q.imm;
			ci = (o == 1 || o >= 5) ? int'(mf.c) : 0;
			s = (o <= 1) ? a + b + ci : a - b - ci;
			hs = (o <= 1) ? a % 16 + b % 16 + ci : a % 16 - b % 16 - ci;
			r = 16'(s[7:0]);
			mf.c = s < 0 || s > 255;
			mf.h = hs < 0 || hs > 15;
			mf.v = (o <= 1) ? (a[7] == b[7] && r[7] != a[7]) : (a[7] != b[7] && r[7] != a[7]);
		end else if (o == 2 || o == 7) begin
			a = {q.dst_hi, q.dst};
			s = (o == 2) ? a + q.imm : a - q.imm;
			r = s[15:0];
			mf.c = s < 0 || s > 65535;
			mf.v = (o == 2) ? !q.dst_hi[7] && r[15] : q.dst_hi[7] && !r[15];
			mf.n = r[15];
			mf.z = r == 16'h0000;
			mf.s = mf.n ^ mf.v;
		end else if (o <= 15) begin
			if (o == 9 || o == 11 || o == 13 || o == 14) b = q.imm;
			r = 16'((o <= 9) ? a & b : (o == 12) ? a ^ b : (o == 14) ? a & ~b : (o == 15) ? a : a | b);
			mf.v = 1'b0;
		end else begin
			if (o != 16 && o != 19 && a > 127) a -= 256;
			if ((o == 17 || o == 20) && b > 127) b -= 256;
			s = a * b;
			r = s[15:0];
			mf.c = r[15];
			if (o >= 19) r = r << 1;
			mf.z = r == 16'h0000;
		end
		if (!pr) begin
			mf.n = r[7];
			mf.z = r[7:0] == 8'h00;
		end
		mr[ix] = r[7:0];
		if (pr) mr[ix + 5'h01] = r[15:8];
		eq.push_back({pr, ix, r, mf});
	endtask
	task automatic take;
		int k;
		k = 0;
		do begin
			@(negedge mclk_in);
			k++;
		end while (busy_out !== 1'b0 && k < 8);
		if (k >= 8) begin
			n_fail++;
			wrap_up;
		end
		@(posedge mclk_in);
	endtask
	task automatic go(input int o, input bit chain);
		eau_pkg::eau_req_t q;
		int k;
		q.op = eau_pkg::eau_op_t'(o);
		q.dst_idx = (o == 2 || o == 7) ? 5'(24 + 2 * ($urandom % 4)) : 5'(2 + $urandom % 22);
		q.dst = mr[q.dst_idx];
		q.dst_hi = mr[q.dst_idx + 5'h01];
		q.src = mr[$urandom % 32];
		q.imm = ($urandom % 3 == 0) ? 8'hFF : 8'($urandom);
		@(posedge mclk_in);
		req_in <= 1'b1;
		req_data_in <= q;
		push(q);
		take();
		// The add is held through the busy edge and must be taken one edge later.
		if (chain && (o == 2 || o == 7 || o >= 16)) begin
			q.op = eau_pkg::EAU_ADD;
			q.dst_idx = 5'h05;
			q.dst = mr[5];
			q.src = mr[0];
			req_data_in <= q;
			push(q);
			take();
		end
		req_in <= 1'b0;
		for (k = 0; k < 8 && eq.size() > 0; k++) @(negedge mclk_in);
		chk("pending results", 16'(eq.size()), 16'h0000);
		// A result that never came means the stream is out of step, so stop here.
		if (eq.size() != 0) wrap_up;
	endtask
	always @(negedge mclk_in) if (done_out === 1'b1) begin
		if (eq.size() == 0) chk("spare done", 16'h0001, 16'h0000);
		else begin
			e = eq.pop_front();
			chk("wr_en", 16'(ans_out.wr_en), 16'h0001);
			chk("pair", {ans_out.wr_pair, 10'h000, ans_out.idx}, {e[27], 10'h000, e[26:22]});
			chk("data", e[27] ? ans_out.data : {8'h00, ans_out.data[7:0]}, e[21:6]);
			chk("flags", 16'(flags_out), 16'(e[5:0]));
		end
	end
	initial begin
		int i;
		i = $urandom(32'h1133170F);
		for (i = 0; i < 32; i++) mr[i] = 8'(i * 29);
		mf = '0;
		repeat (3) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (i = 0; i < 176; i++) go(i % 22, i >= 88);
		repeat (2) @(negedge mclk_in);
		for (i = 0; i < 32; i++) chk("register", 16'(u_rf.regs[i]), 16'(mr[i]));
		wrap_up;
	end
endmodule
